// ### include/mcss_regs.svh
// named constants for the motor current and stall supervisor
// assumes: included by bare name from the supervisor rtl file only; the package does not include it
`ifndef MCSS_REGS_SVH
`define MCSS_REGS_SVH

// =====================================================================
// clock and time bases
`define MCSS_CLK_PERIOD_PS     32'd5000
`define MCSS_SECOND_PS         64'd1000000000000
`define MCSS_CUTBACK_STEP_MS   32'd100
`define MCSS_MS_PS             64'd1000000000

// =====================================================================
// setting ranges
`define MCSS_STALL_SPEED_MAX   8'hff
`define MCSS_PCT_MAX           7'h64
`define MCSS_STALL_TMO_MIN     6'h10
`define MCSS_STALL_TMO_MAX     6'h20
`define MCSS_MAX_CUR_TIME_MAX  7'h78
`define MCSS_AUTO_PCT_MIN      6'h05
`define MCSS_AUTO_PCT_MAX      6'h32
`define MCSS_SCALER_MIN_V      5'h14
`define MCSS_SCALER_MAX_V      5'h1b
`define MCSS_RES_MAX_MOHM      10'h320

// =====================================================================
// rated current ceilings per hardware variant, amps
`define MCSS_VAR_A_CEIL        7'h2d
`define MCSS_VAR_B_CEIL        7'h46
`define MCSS_VAR_C_CEIL        7'h23

// =====================================================================
// arithmetic helpers
`define MCSS_FRAC_BITS         8
`define MCSS_VOLT_TO_DV        9'h00a
`define MCSS_PCT_DIV           22'h000064

`endif

// ### include/mcss_pkg.sv
// types shared by the motor current and stall supervisor
// assumes: constants come from mcss_regs.svh
package mcss_pkg;

    // =================================================================
    // hardware variants, each with its own rated current ceiling
    typedef enum logic [1:0]
    {
        VAR_A = 2'h0,
        VAR_B = 2'h1,
        VAR_C = 2'h2
    } variant_t;

    // =================================================================
    // programmable settings, held by software outside this block
    typedef struct packed
    {
        logic [7:0] stall_speed;      // estimator units, 0..255
        logic [6:0] stall_duty_pct;   // percent
        logic [5:0] stall_timeout_s;  // seconds, 16..32
        logic [6:0] max_cur_time_s;   // seconds, 0..120
        logic [6:0] cutback_gain_pct; // percent
        variant_t   variant;
        logic [6:0] rated_current_a;  // amps
        logic [5:0] autotest_pct;     // percent of main limit, 5..50
        logic [4:0] speed_scaler_v;   // volts, 20..27
        logic [9:0] sys_res_mohm;     // milliohms, 0..800
    } cfg_t;

    // =================================================================
    // live drive measurements from same-clock logic
    typedef struct packed
    {
        logic [7:0] est_speed;
        logic [6:0] duty_pct;
        logic       at_main_limit;
        logic [6:0] main_limit_a;
        logic       autotest;
        logic [8:0] batt_dv;          // battery, tenths of a volt
    } drive_t;

    // =================================================================
    // supervisor outputs
    typedef struct packed
    {
        logic [6:0] cur_limit_a;
        logic       cutback;
        logic [8:0] motor_v_cap_dv;
        logic [9:0] res_mohm;
        logic       stall_fault;
    } status_t;

endpackage : mcss_pkg

// ### rtl/tick_gen.sv
// periodic one-cycle tick from a free-running divider
// assumes: a single clock, asynchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module tick_gen
#(
    parameter int unsigned PERIOD = 200000000,
    parameter int unsigned W      = 28
)
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // tick
    output logic      o_tick
);

    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         wrap;

    // wrap at the end of each period
    assign wrap     = (cnt_reg == LAST);
    assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;

    // divider counter and registered tick
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_reg <= '0;
            o_tick  <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            o_tick  <= wrap;
        end
    end

endmodule : tick_gen

`default_nettype wire

// ### rtl/persist_timer.sv
// seconds counter that runs while a condition holds
// assumes: i_tick is a one-cycle pulse from the same clock
`timescale 1ns/10ps
`default_nettype none

module persist_timer
#(
    parameter int unsigned W = 8
)
(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // condition and time base
    input  wire logic         i_run,
    input  wire logic         i_tick,
    // elapsed whole ticks, saturating
    output logic [W-1:0]      o_count
);

    logic [W-1:0] cnt_next;
    logic         sat;

    // saturate so a long condition never wraps back to zero
    assign sat      = &o_count;
    assign cnt_next = !i_run ? '0
                    : (i_tick && !sat) ? o_count + 1'b1
                    : o_count;

    // count register, cleared as soon as the condition drops
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_count <= '0;
        else
            o_count <= cnt_next;
    end

endmodule : persist_timer

`default_nettype wire

// ### rtl/motor_current_stall_supervisor.sv
// motor current cutback, voltage cap and stall fault supervisor
// assumes: settings and measurements come from logic on i_clk,
// settings stay steady while the drive is running
`timescale 1ns/10ps
`default_nettype none
`include "mcss_regs.svh"

// Operation
// - stall fault when speed and duty both low beyond the timeout
// - stall speed setting 0..255 compared with estimated speed
// - stall duty setting 0..100 percent compared with present duty
// - stall timeout 16..32 seconds sets required persistence
// - time running at main limit, allow at most 0..120 seconds
// - after expiry ramp limit toward rated current at gain rate
// - rated current ceiling 45, 70 or 35 amps by variant
// - during resistance test limit current to 5..50 percent of main
// - cap applied motor voltage at 20..27 volts
// - hold 0..800 milliohm resistance for compensation and estimate
module motor_current_stall_supervisor
#(
    parameter int unsigned CYCLES_PER_SEC =
        int'(`MCSS_SECOND_PS / 64'(`MCSS_CLK_PERIOD_PS)),
    parameter int unsigned CYCLES_PER_STEP =
        int'((64'(`MCSS_CUTBACK_STEP_MS) * `MCSS_MS_PS)
             / 64'(`MCSS_CLK_PERIOD_PS)),
    parameter int unsigned TIMER_W = 8
)
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // settings and live measurements
    input  wire mcss_pkg::cfg_t   i_cfg,
    input  wire mcss_pkg::drive_t i_drive,
    // stall fault acknowledge, one-cycle pulse
    input  wire logic             i_fault_clr,
    // supervisor results
    output mcss_pkg::status_t     o_status
);

    // fraction bits of the internal limit, so that a small gain still
    // moves the ramp; whole amps alone would round every step to zero
    localparam int FB = `MCSS_FRAC_BITS;

    // =================================================================
    // time bases
    // both dividers free-run from reset, so any timed span carries up
    // to one tick of phase error: whole seconds are the resolution
    logic sec_tick;
    logic step_tick;

    // one tick a second for both persistence timers
    tick_gen
    #(
        .PERIOD (CYCLES_PER_SEC),
        .W      ($clog2(CYCLES_PER_SEC + 1))
    )
    u_sec_tick
    (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (sec_tick)
    );

    // cutback ramp step interval
    tick_gen
    #(
        .PERIOD (CYCLES_PER_STEP),
        .W      ($clog2(CYCLES_PER_STEP + 1))
    )
    u_step_tick
    (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (step_tick)
    );

    // =================================================================
    // setting clamps, so an out-of-range value cannot upset the math
    // clamping beats rejecting: a bad setting still gives a safe,
    // bounded behaviour instead of a stuck or wrapped comparison
    logic [6:0] duty_th;
    logic [5:0] stall_tmo;
    logic [6:0] max_time;
    logic [6:0] gain;
    logic [6:0] rated_ceil;
    logic [6:0] rated_a;
    logic [5:0] auto_pct;
    logic [4:0] scaler_v;
    logic [9:0] res_mohm;

    assign duty_th = (i_cfg.stall_duty_pct > `MCSS_PCT_MAX)
                   ? `MCSS_PCT_MAX : i_cfg.stall_duty_pct;
    assign stall_tmo = (i_cfg.stall_timeout_s < `MCSS_STALL_TMO_MIN)
                     ? `MCSS_STALL_TMO_MIN
                     : (i_cfg.stall_timeout_s > `MCSS_STALL_TMO_MAX)
                     ? `MCSS_STALL_TMO_MAX : i_cfg.stall_timeout_s;
    assign max_time = (i_cfg.max_cur_time_s > `MCSS_MAX_CUR_TIME_MAX)
                    ? `MCSS_MAX_CUR_TIME_MAX : i_cfg.max_cur_time_s;
    assign gain = (i_cfg.cutback_gain_pct > `MCSS_PCT_MAX)
                ? `MCSS_PCT_MAX : i_cfg.cutback_gain_pct;
    // the spare variant code falls back to the first ceiling
    // variant ceiling
    assign rated_ceil = (i_cfg.variant == mcss_pkg::VAR_B) ? `MCSS_VAR_B_CEIL
                      : (i_cfg.variant == mcss_pkg::VAR_C) ? `MCSS_VAR_C_CEIL
                      : `MCSS_VAR_A_CEIL;
    assign rated_a = (i_cfg.rated_current_a > rated_ceil)
                   ? rated_ceil : i_cfg.rated_current_a;
    assign auto_pct = (i_cfg.autotest_pct < `MCSS_AUTO_PCT_MIN)
                    ? `MCSS_AUTO_PCT_MIN
                    : (i_cfg.autotest_pct > `MCSS_AUTO_PCT_MAX)
                    ? `MCSS_AUTO_PCT_MAX : i_cfg.autotest_pct;
    assign scaler_v = (i_cfg.speed_scaler_v < `MCSS_SCALER_MIN_V)
                    ? `MCSS_SCALER_MIN_V
                    : (i_cfg.speed_scaler_v > `MCSS_SCALER_MAX_V)
                    ? `MCSS_SCALER_MAX_V : i_cfg.speed_scaler_v;
    assign res_mohm = (i_cfg.sys_res_mohm > `MCSS_RES_MAX_MOHM)
                    ? `MCSS_RES_MAX_MOHM : i_cfg.sys_res_mohm;

    // =================================================================
    // stall detection
    logic               speed_low;
    logic               duty_low;
    logic               stall_cond;
    logic [TIMER_W-1:0] stall_secs;
    logic               stall_event;
    logic               fault_reg;
    logic               fault_next;

    // strict compares: a speed or duty equal to its threshold is not
    // low, so it breaks the stall run and restarts the timer
    // speed comparison
    assign speed_low  = (i_drive.est_speed < i_cfg.stall_speed);
    assign duty_low   = (i_drive.duty_pct < duty_th);
    assign stall_cond = speed_low && duty_low;

    persist_timer
    #(
        .W       (TIMER_W)
    )
    u_stall_timer
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_run   (stall_cond),
        .i_tick  (sec_tick),
        .o_count (stall_secs)
    );

    // the count only steps on a tick, so the fault lands between the
    // timeout and one second past it, never before
    // strictly longer than the timeout
    assign stall_event = stall_cond
                       && (stall_secs > TIMER_W'(stall_tmo));
    // sticky fault, a new event beats a clear
    assign fault_next  = stall_event || (fault_reg && !i_fault_clr);

    // =================================================================
    // time at main current limit
    logic [TIMER_W-1:0] limit_secs;
    logic               time_expired;

    // leaving the main limit for one cycle restarts the allowance
    // count seconds spent at main limit
    persist_timer
    #(
        .W       (TIMER_W)
    )
    u_limit_timer
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_run   (i_drive.at_main_limit),
        .i_tick  (sec_tick),
        .o_count (limit_secs)
    );

    // a zero setting expires at once, so cutback follows the first
    // cycle at the main limit
    // allowed duration used up
    assign time_expired = (limit_secs >= TIMER_W'(max_time));

    // =================================================================
    // cutback of the current limit, fixed point with FB fraction bits
    logic [6+FB:0]  main_fx;
    logic [6+FB:0]  rated_fx;
    logic [6+FB:0]  lim_reg;
    logic [6+FB:0]  lim_next;
    logic [6+FB:0]  lim_diff;
    logic [21:0]    dec_prod;
    logic [6+FB:0]  dec_step;
    logic [6+FB:0]  floor_fx;
    logic           cut_reg;
    logic           cut_next;
    logic           cut_start;
    logic           over_main;
    logic [6+FB:0]  lim_step;

    // both limits in one fixed point, whole amps in the top bits
    assign main_fx  = {i_drive.main_limit_a, FB'(0)};
    assign rated_fx = {rated_a, FB'(0)};
    // never cut below rated, nor hold above the present main limit
    assign floor_fx = (rated_fx < main_fx) ? rated_fx : main_fx;
    assign lim_diff = (lim_reg > floor_fx) ? lim_reg - floor_fx : '0;
    assign dec_prod = (22'(lim_diff) * 22'(gain)) / `MCSS_PCT_DIV;
    // a nonzero gain always makes progress, even for a tiny gap
    assign dec_step = (gain != '0 && dec_prod == '0 && lim_diff != '0)
                    ? (7+FB)'(1) : dec_prod[6+FB:0];

    // cutback holds until the main limit falls to the ramp, so a short
    // release of the limit flag does not snap the current back up
    // ramp down after expiry, end cutback once the main limit falls to the ramp
    assign cut_next = time_expired && i_drive.at_main_limit
                    ? 1'b1
                    : (lim_reg >= main_fx) ? 1'b0 : cut_reg;
    // the first cycle of cutback loads the main limit, so the ramp never
    // starts from what the register held before, such as zero after reset
    assign cut_start = cut_next && !cut_reg;
    // a main limit lowered under the ramp takes over at once
    assign over_main = (lim_reg > main_fx);
    // one ramp step per step tick, held in between
    assign lim_step  = step_tick ? lim_reg - dec_step : lim_reg;
    assign lim_next  = (!cut_next || cut_start || over_main) ? main_fx
                     : lim_step;

    // =================================================================
    // resistance test limit and voltage cap
    logic [12:0] auto_prod;
    logic [6:0]  auto_lim_a;
    logic [6:0]  run_lim_a;
    logic [6:0]  lim_out_a;
    logic [8:0]  scaler_dv;
    logic [8:0]  v_cap_dv;

    // while testing the ramp is bypassed; the test limit is far lower
    // fraction of the main limit while testing
    assign auto_prod  = (13'(i_drive.main_limit_a) * 13'(auto_pct))
                      / 13'(`MCSS_PCT_MAX);
    assign auto_lim_a = auto_prod[6:0];
    assign run_lim_a  = lim_reg[6+FB:FB];
    assign lim_out_a  = i_drive.autotest ? auto_lim_a : run_lim_a;

    // the cap is a ceiling only: a battery below it passes unchanged,
    // which keeps top speed steady across the charge above the cap
    // smaller of battery and scaler voltage
    assign scaler_dv = 9'(scaler_v) * `MCSS_VOLT_TO_DV;
    assign v_cap_dv  = (i_drive.batt_dv < scaler_dv)
                     ? i_drive.batt_dv : scaler_dv;

    // =================================================================
    // state registers
    // every state register clears on reset; the limit reloads from the
    // main limit on the first edge after release
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fault_reg <= 1'b0;
            lim_reg   <= '0;
            cut_reg   <= 1'b0;
        end
        else
        begin
            fault_reg <= fault_next;
            lim_reg   <= lim_next;
            cut_reg   <= cut_next;
        end
    end

    // =================================================================
    // registered outputs: cap, resistance and test limit one cycle behind their inputs; fault, cutback and ramp limit two
    // registering every field keeps glitches of the clamps and products
    // off the status pins
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_status <= '0;
        else
        begin
            o_status.cur_limit_a    <= lim_out_a;
            o_status.cutback        <= cut_reg;
            o_status.motor_v_cap_dv <= v_cap_dv;
            o_status.res_mohm       <= res_mohm;
            o_status.stall_fault    <= fault_reg;
        end
    end

endmodule : motor_current_stall_supervisor

`default_nettype wire

// ### tb/mcss_chk.sv
// assertion checker for the motor current and stall supervisor
// assumes: bound onto the top module, one clock, async reset
`timescale 1ns/10ps
`default_nettype none

module mcss_chk
#(
    parameter int unsigned CYCLES_PER_SEC = 10
)
(
    // clock and reset
    input wire logic              i_clk,
    input wire logic              i_rst,
    // watched ports
    input wire mcss_pkg::cfg_t    i_cfg,
    input wire mcss_pkg::drive_t  i_drive,
    input wire logic              i_fault_clr,
    input wire mcss_pkg::status_t o_status
);
    // =============================================================
    // expected values from settings
    logic [6:0]  duty_thr;
    logic [6:0]  ceil_a;
    logic [6:0]  rated_a;
    logic [6:0]  floor_a;
    logic [6:0]  auto_a;
    logic [5:0]  tmo_s;
    logic [8:0]  cap_dv;
    logic [8:0]  vcap_dv;
    logic        cond;
    logic [15:0] cond_cyc;
    logic [15:0] lim_cyc;
    logic [1:0]  live_cnt;
    int          tmo_cyc;
    int          mct_cyc;

    // clamps and minima, all combinational
    assign duty_thr = (i_cfg.stall_duty_pct > 7'h64) ? 7'h64
                                                     : i_cfg.stall_duty_pct;
    assign tmo_s = (i_cfg.stall_timeout_s < 6'h10) ? 6'h10 :
                   (i_cfg.stall_timeout_s > 6'h20) ? 6'h20 :
                   i_cfg.stall_timeout_s;
    assign cond = (i_drive.est_speed < i_cfg.stall_speed) &&
                  (i_drive.duty_pct < duty_thr);
    assign ceil_a = (i_cfg.variant == mcss_pkg::VAR_B) ? 7'h46 :
                    (i_cfg.variant == mcss_pkg::VAR_C) ? 7'h23 : 7'h2d;
    assign rated_a = (i_cfg.rated_current_a < ceil_a) ?
                     i_cfg.rated_current_a : ceil_a;
    assign floor_a = (rated_a < i_drive.main_limit_a) ? rated_a
                                                      : i_drive.main_limit_a;
    assign auto_a = 7'((14'(i_drive.main_limit_a) *
                        14'(i_cfg.autotest_pct)) / 14'h0064);
    assign cap_dv = 9'(i_cfg.speed_scaler_v) * 9'h00a;
    assign vcap_dv = (i_drive.batt_dv < cap_dv) ? i_drive.batt_dv : cap_dv;
    assign tmo_cyc = int'(tmo_s) * int'(CYCLES_PER_SEC);
    assign mct_cyc = int'(i_cfg.max_cur_time_s) * int'(CYCLES_PER_SEC);

    // run lengths; the tick phase is unseen, so bounds carry slack
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cond_cyc <= 16'h0000;
            lim_cyc  <= 16'h0000;
            live_cnt <= 2'h0;
        end
        else
        begin
            cond_cyc <= cond ? cond_cyc + 16'h0001 : 16'h0000;
            lim_cyc  <= i_drive.at_main_limit ? lim_cyc + 16'h0001
                                              : 16'h0000;
            live_cnt <= (live_cnt == 2'h3) ? live_cnt : live_cnt + 2'h1;
        end
    end

    // =============================================================
    // properties, held off until outputs carry post-reset values
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst || live_cnt != 2'h3);

    a_vcap_min: assert property (
        o_status.motor_v_cap_dv == $past(vcap_dv))
        else $error("motor voltage cap mismatch");
    a_auto_limit: assert property (
        $past(i_drive.autotest) |-> o_status.cur_limit_a == $past(auto_a))
        else $error("autotest current limit mismatch");
    a_stall_early: assert property (
        $rose(o_status.stall_fault) |->
        int'($past(cond_cyc, 2)) + 2 >= tmo_cyc)
        else $error("stall fault before timeout");
    a_stall_late: assert property (
        int'(cond_cyc) == tmo_cyc + 2 * int'(CYCLES_PER_SEC) |->
        ##[1:4] o_status.stall_fault)
        else $error("stall fault missing after timeout");
    a_stall_hold: assert property (
        $fell(o_status.stall_fault) |->
        $past(i_fault_clr) || $past(i_fault_clr, 2))
        else $error("stall fault dropped without clear");
    a_cut_early: assert property (
        $rose(o_status.cutback) |->
        int'(lim_cyc) + int'(CYCLES_PER_SEC) + 3 >= mct_cyc)
        else $error("cutback before max current time");
    a_cut_late: assert property (
        int'(lim_cyc) == mct_cyc + int'(CYCLES_PER_SEC) + 2 |->
        ##[0:4] o_status.cutback)
        else $error("cutback missing after max current time");
    a_cut_floor: assert property (
        o_status.cutback && !$past(i_drive.autotest) |->
        o_status.cur_limit_a >= $past(floor_a))
        else $error("cutback below rated floor");

    c_stall: cover property ($rose(o_status.stall_fault));
    c_cut: cover property ($rose(o_status.cutback));
    c_auto: cover property (i_drive.autotest && o_status.cur_limit_a != 7'h00);
endmodule : mcss_chk

`default_nettype wire

// ### tb/motor_model.sv
// brushed dc motor seen through the drive: speed and limit flag
// assumes: bench commands duty and a locked rotor, one clock
`timescale 1ns/10ps
`default_nettype none

module motor_model
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // commands
    input  wire logic [6:0] i_duty,
    input  wire logic       i_jam,
    // sensed
    output logic [7:0]      o_speed,
    output logic            o_at_limit
);
    // speed climbs toward duty one unit a cycle and drops to it at once; a locked rotor reads zero
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst || i_jam)
            o_speed <= 8'h00;
        else if (o_speed < {1'b0, i_duty})
            o_speed <= o_speed + 8'h01;
        else
            o_speed <= {1'b0, i_duty};
    end
    // stalled rotor under drive pulls maximum current
    assign o_at_limit = i_jam && (i_duty != 7'h00);
endmodule : motor_model

`default_nettype wire

// ### tb/motor_current_stall_supervisor_tb_top.sv
// testbench for the motor current and stall supervisor
// assumes: shortened time bases, ten cycles a second, two a step
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    n_mismatch++; $display("wrong value %s expected %0d seen %0d", \
    nm, e, g); end end

module motor_current_stall_supervisor_tb_top;
    // =============================================================
    // stimulus and observed signals
    logic              i_clk = 1'b0;
    logic              i_rst = 1'b1;
    logic              fault_clr = 1'b0;
    logic              jam = 1'b0;
    logic              autotest = 1'b0;
    logic [6:0]        duty = 7'h00;
    logic [6:0]        main = 7'h50;
    logic [8:0]        batt = 9'h0f0;
    logic [7:0]        speed;
    logic              atl;
    int                n_mismatch = 0;
    int                compares = 0;
    mcss_pkg::drive_t  drv;
    mcss_pkg::status_t st;
    mcss_pkg::cfg_t    cfg = '{8'h00, 7'h0a, 6'h10, 7'h78, 7'h00,
                              mcss_pkg::VAR_A, 7'h64, 6'h19, 5'h17, 10'h1f4};

    always #2.5 i_clk = ~i_clk;
    assign drv = '{speed, duty, atl, main, autotest, batt};

    motor_model motor_model_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_duty(duty), .i_jam(jam), .o_speed(speed), .o_at_limit(atl));
    motor_current_stall_supervisor #(.CYCLES_PER_SEC(10),
        .CYCLES_PER_STEP(2)) motor_current_stall_supervisor_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg), .i_drive(drv),
        .i_fault_clr(fault_clr), .o_status(st));

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc

    // voltage cap above and below, resistance clamp
    task automatic t_cap();
        batt = 9'h10e;
        cfg.sys_res_mohm = 10'h384;
        cyc(3);
        `CHK("vcap", 9'h0e6, st.motor_v_cap_dv)
        `CHK("res", 10'h320, st.res_mohm)
        batt = 9'h0d7;
        cfg.sys_res_mohm = 10'h1f4;
        cyc(3);
        `CHK("vcap", 9'h0d7, st.motor_v_cap_dv)
        `CHK("res", 10'h1f4, st.res_mohm)
        $display("test cap done");
    endtask : t_cap

    // autotest limit at two percentages, back to back
    task automatic t_auto();
        autotest = 1'b1;
        cyc(3);
        `CHK("auto", 7'h14, st.cur_limit_a)
        main = 7'h64;
        cfg.autotest_pct = 6'h32;
        cyc(2);
        `CHK("auto", 7'h32, st.cur_limit_a)
        autotest = 1'b0;
        main = 7'h50;
        $display("test auto done");
    endtask : t_auto

    // persistence, restart on a one-cycle break, clear, thresholds
    task automatic t_stall();
        cfg.stall_speed = 8'h0b;
        duty = 7'h05;
        cyc(150);
        duty = 7'h0a;
        cyc(1);
        duty = 7'h05;
        cyc(155);
        `CHK("stall", 1'b0, st.stall_fault)
        cyc(55);
        `CHK("stall", 1'b1, st.stall_fault)
        fault_clr = 1'b1;
        cyc(1);
        fault_clr = 1'b0;
        cyc(3);
        `CHK("stall", 1'b1, st.stall_fault)
        cfg.stall_speed = 8'h05;
        cyc(2);
        fault_clr = 1'b1;
        cyc(1);
        fault_clr = 1'b0;
        cyc(200);
        `CHK("stall", 1'b0, st.stall_fault)
        cfg.stall_speed = 8'h00;
        $display("test stall done");
    endtask : t_stall

    // max current time, zero gain hold, floor per variant
    task automatic t_cut();
        logic [6:0] ceil_tab [4] = '{7'h2d, 7'h46, 7'h23, 7'h2d};
        cfg.max_cur_time_s = 7'h03;
        main = 7'h5a;
        duty = 7'h1e;
        jam = 1'b1;
        cyc(25);
        `CHK("cutback", 1'b0, st.cutback)
        cyc(25);
        `CHK("cutback", 1'b1, st.cutback)
        `CHK("limit", 7'h5a, st.cur_limit_a)
        cfg.cutback_gain_pct = 7'h32;
        for (int v = 0; v < 4; v++)
        begin
            i_rst = 1'b1;
            cfg.variant = mcss_pkg::variant_t'(v);
            cyc(2);
            i_rst = 1'b0;
            cyc(200);
            `CHK("floor", ceil_tab[v], st.cur_limit_a)
        end
        jam = 1'b0;
        $display("test cut done");
    endtask : t_cut

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // main sequence
    initial
    begin
        cyc(10);
        i_rst = 1'b0;
        cyc(3);
        t_cap();
        t_auto();
        t_stall();
        t_cut();
        print_verdict();
    end

    // whole run is near 1450 cycles; cut a hang at about fourteen times that
    initial
    begin
        #100us;
        n_mismatch++;
        print_verdict();
    end
endmodule : motor_current_stall_supervisor_tb_top

bind motor_current_stall_supervisor mcss_chk
    #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) mcss_chk_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .i_drive(i_drive),
    .i_fault_clr(i_fault_clr), .o_status(o_status));

`default_nettype wire
